// ===== logic/smds_core.sv
// Purpose: Bit-serial multiply step and divide step arithmetic with APB registers
// Assumes: One clock, APB master on the same clock, software loads operands first
// Notes:   Each phase is one word time of bit times 0..24, one bit per clock
`default_nettype none
module smds_core
  import smds_pkg::*;
#(
  parameter int unsigned PC_W = 14
) (
  input  wire logic              CLK_I,
  input  wire logic              RST_B_I,
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire logic [ADDR_W-1:0] PADDR_I,
  input  wire logic [31:0]       PWDATA_I,
  output var  logic [31:0]       PRDATA_O,
  output var  logic              PREADY_O,
  output var  logic              PSLVERR_O,
  output var  logic              BUSY_O,
  output var  logic              OVERFLOW_O,
  output var  logic              PC_INCR_O
);

  // Refused at elaboration: the counter cannot be wider than a data word
  if (PC_W < 1 || PC_W > 24) begin : g_pc_w_check
    $error("PC_W out of range");
  end

  // Multiplicand bit for the adder, once or twice, sign extended
  function automatic logic mul_bit(input logic [23:0] m, input logic dbl, input logic [4:0] i);
    logic [5:0] idx;
    idx = {1'b0, i};
    if (dbl && i == 5'h00) begin
      return 1'b0;
    end
    if (dbl) begin
      idx = idx - 6'h01;
    end
    if (idx > 6'h17) begin
      return m[23];
    end
    return m[idx[4:0]];
  endfunction

  smds_state_t       state_reg;
  logic [4:0]        bit_time_reg;
  logic              is_div_reg;
  logic [ACC_W-1:0]  acc_reg;
  logic [23:0]       ext_reg;
  logic [23:0]       opd_reg;
  logic [23:0]       sum_reg;
  logic [PC_W-1:0]   pc_reg;
  logic              borrow_select_flop;
  logic              pair_alike_flop;
  logic              zero_gate_flop;
  logic              carry_flop;
  logic              acc_lsb_stage;
  logic              overflow_flop;
  logic              pc_increment_flop;
  logic              pready_reg;
  logic              pslverr_reg;
  logic [31:0]       prdata_reg;

  // Bus decode
  wire logic         apb_access  = PSEL_I & PENABLE_I;
  wire logic         apb_done    = apb_access & pready_reg;
  wire logic         wr_en       = apb_done & PWRITE_I & ~pslverr_reg;
  wire logic         sel_ctrl    = (PADDR_I == OFS_CTRL);
  wire logic         sel_status  = (PADDR_I == OFS_STATUS);
  wire logic         sel_acc     = (PADDR_I == OFS_ACC);
  wire logic         sel_ext     = (PADDR_I == OFS_EXT);
  wire logic         sel_opd     = (PADDR_I == OFS_OPERAND);
  wire logic         sel_pc      = (PADDR_I == OFS_PC);
  wire logic         addr_hit    = sel_ctrl | sel_status | sel_acc | sel_ext | sel_opd | sel_pc;
  wire logic         idle        = (state_reg == SMDS_IDLE);
  wire logic         start_mul   = wr_en & sel_ctrl & idle & PWDATA_I[CTRL_MUL_BIT];
  wire logic         start_div   = wr_en & sel_ctrl & idle & ~PWDATA_I[CTRL_MUL_BIT]
                                   & PWDATA_I[CTRL_DIV_BIT];
  wire logic         ovf_clr     = wr_en & sel_ctrl & PWDATA_I[CTRL_OVCLR_BIT];
  wire logic         load_ok     = wr_en & idle;

  wire logic [31:0]  status_word = {19'h0_0000, bit_time_reg, 4'h0, is_div_reg,
                                    (state_reg == SMDS_PH6), overflow_flop, ~idle};
  wire logic [31:0]  rd_mux      = sel_ctrl   ? ZERO_DATA :
                                   sel_status ? status_word :
                                   sel_acc    ? {8'h00, acc_reg[23:0]} :
                                   sel_ext    ? {8'h00, ext_reg} :
                                   sel_opd    ? {8'h00, opd_reg} :
                                   sel_pc     ? 32'(pc_reg) : ZERO_DATA;

  // Word timing
  wire logic         last_bit    = (bit_time_reg == FINAL_BIT);
  wire logic         ph0         = (state_reg == SMDS_PH0);
  wire logic         ph6         = (state_reg == SMDS_PH6);
  wire logic         acc_sign    = acc_reg[23];

  // Adder inputs
  // delayed lsb
  wire logic         x_div       = pair_alike_flop;
  wire logic         x_mul       = acc_reg[bit_time_reg];
  wire logic         adder_input_one = is_div_reg ? x_div : x_mul;
  wire logic         m_mul       = mul_bit(opd_reg, pair_alike_flop, bit_time_reg);
  wire logic         m_div       = (bit_time_reg > 5'h17) ? opd_reg[23] : opd_reg[bit_time_reg];
  wire logic         m_gated     = is_div_reg ? m_div : (m_mul & ~zero_gate_flop);
  wire logic         blk_sub     = borrow_select_flop & (is_div_reg | ~zero_gate_flop);
  wire logic         adder_input_two = m_gated ^ blk_sub;
  wire logic         sum_bit     = adder_input_one ^ adder_input_two ^ carry_flop;
  wire logic         carry_out   = (adder_input_one & adder_input_two)
                                   | (carry_flop & (adder_input_one ^ adder_input_two));
  wire logic         hold_lsb    = ~is_div_reg & pair_alike_flop & (bit_time_reg == 5'h00);
  wire logic         carry_next  = hold_lsb ? carry_flop : carry_out;

  // Multiply result, 26 bits before the final shift
  wire logic         y_top       = mul_bit(opd_reg, pair_alike_flop, FINAL_BIT) & ~zero_gate_flop;
  wire logic         top_bit     = acc_reg[25] ^ (y_top ^ blk_sub) ^ carry_next;
  wire logic [25:0]  mul_full    = {top_bit, sum_bit, sum_reg[23:1], acc_lsb_stage};
  wire logic         mul_ovf     = borrow_select_flop & pair_alike_flop & ~zero_gate_flop
                                   & (mul_full[25] ^ mul_full[24]);
  // zeros on overflow
  // Taken from bit 23: after an overflowed result the upper copies no longer match the sign
  wire logic         fill0       = overflow_flop ? 1'b0 : acc_reg[23];
  wire logic         quot_bit    = ~acc_sign;

  // Bus slave: one wait state, answer registered
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= ZERO_DATA;
    end else begin
      pready_reg  <= apb_access & ~pready_reg;
      if (apb_access & ~pready_reg) begin
        pslverr_reg <= ~addr_hit;
        prdata_reg  <= PWRITE_I ? ZERO_DATA : rd_mux;
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // Step sequencer
  // bit times
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_reg    <= SMDS_IDLE;
      bit_time_reg <= 5'h00;
      is_div_reg   <= 1'b0;
    end else begin
      case (state_reg)
        SMDS_IDLE: begin
          bit_time_reg <= 5'h00;
          if (start_mul | start_div) begin
            state_reg  <= SMDS_PH0;
            is_div_reg <= start_div;
          end
        end
        SMDS_PH0: begin
          bit_time_reg <= last_bit ? 5'h00 : bit_time_reg + 5'h01;
          if (last_bit) begin
            state_reg <= SMDS_PH6;
          end
        end
        default: begin
          bit_time_reg <= last_bit ? 5'h00 : bit_time_reg + 5'h01;
          if (last_bit) begin
            state_reg <= SMDS_IDLE;
          end
        end
      endcase
    end
  end

  // Control flops
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      borrow_select_flop <= 1'b0;
      pair_alike_flop    <= 1'b0;
      zero_gate_flop     <= 1'b0;
      carry_flop         <= 1'b0;
      acc_lsb_stage      <= 1'b0;
    end else if (ph0) begin
      if (!is_div_reg && bit_time_reg == SU_PICK_BIT) begin
        borrow_select_flop <= ext_reg[2];
      end
      if (!is_div_reg && bit_time_reg == DC_PICK_BIT) begin
        pair_alike_flop <= ~(ext_reg[1] ^ ext_reg[0]);
      end
      if (last_bit) begin
        if (is_div_reg) begin
          pair_alike_flop    <= ext_reg[23];
          borrow_select_flop <= ~(opd_reg[23] ^ acc_sign);
          carry_flop         <= ~(opd_reg[23] ^ acc_sign);
          zero_gate_flop     <= 1'b0;
        end else begin
          zero_gate_flop <= pair_alike_flop & ~(ext_reg[1] ^ borrow_select_flop);
          carry_flop     <= borrow_select_flop & ~(pair_alike_flop & ~(ext_reg[1]
                            ^ borrow_select_flop));
        end
      end
    end else if (ph6) begin
      carry_flop <= carry_next;
      if (bit_time_reg == 5'h00) begin
        acc_lsb_stage <= hold_lsb ? acc_reg[0] : sum_bit;
      end
      if (is_div_reg) begin
        pair_alike_flop <= acc_reg[bit_time_reg];
      end
      if (last_bit) begin
        borrow_select_flop <= 1'b0;
        pair_alike_flop    <= 1'b0;
        zero_gate_flop     <= is_div_reg ? quot_bit : 1'b0;
      end
    end
  end

  // Serial sum store
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      sum_reg <= WORD_RST;
    end else if (ph6 && !last_bit) begin
      sum_reg[bit_time_reg] <= sum_bit;
    end
  end

  // Accumulator, extension, operand
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      acc_reg <= ACC_RST;
      ext_reg <= WORD_RST;
      opd_reg <= WORD_RST;
    end else if (idle) begin
      if (load_ok && sel_acc) begin
        acc_reg <= {{2{PWDATA_I[23]}}, PWDATA_I[23:0]};
      end
      if (load_ok && sel_ext) begin
        ext_reg <= PWDATA_I[23:0];
      end
      if (load_ok && sel_opd) begin
        opd_reg <= PWDATA_I[23:0];
      end
    end else if (ph0 && last_bit && !is_div_reg) begin
      acc_reg <= {fill0, fill0, fill0, acc_reg[23:1]};
      ext_reg <= {acc_reg[0], ext_reg[23:1]};
    end else if (ph6 && last_bit) begin
      if (is_div_reg) begin
        acc_reg <= {{2{sum_reg[23]}}, sum_reg};
        ext_reg <= {ext_reg[22:0], quot_bit};
      end else begin
        acc_reg <= {mul_full[25], mul_full[25:1]};
        ext_reg <= {acc_lsb_stage, ext_reg[23:1]};
      end
    end
  end

  // Overflow and program counter
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      overflow_flop     <= 1'b0;
      pc_increment_flop <= 1'b0;
      pc_reg            <= '0;
    end else begin
      pc_increment_flop <= ph6 & last_bit;
      if (ph6 && last_bit && !is_div_reg && mul_ovf) begin
        overflow_flop <= 1'b1;
      end else if (ph0 && last_bit && !is_div_reg && overflow_flop) begin
        overflow_flop <= 1'b0;
      end else if (ovf_clr) begin
        overflow_flop <= 1'b0;
      end
      if (ph6 && last_bit) begin
        pc_reg <= pc_reg + 1'b1;
      end else if (load_ok && sel_pc) begin
        pc_reg <= PWDATA_I[PC_W-1:0];
      end
    end
  end

  // Outputs from flops
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      BUSY_O     <= 1'b0;
      OVERFLOW_O <= 1'b0;
    end else begin
      BUSY_O     <= ~idle | start_mul | start_div;
      OVERFLOW_O <= overflow_flop;
    end
  end

  assign PRDATA_O  = prdata_reg;
  assign PREADY_O  = pready_reg;
  assign PSLVERR_O = pslverr_reg;
  assign PC_INCR_O = pc_increment_flop;

endmodule
`default_nettype wire

// ===== pkg/smds_pkg.sv
// Purpose: Shared constants and types for the serial multiply/divide step block
// Assumes: 24-bit words, 25 bit times per word time, APB register access
// Notes:   Offsets are byte addresses of 32-bit aligned registers
`default_nettype none
package smds_pkg;
  localparam int unsigned        WORD_W        = 24;
  localparam int unsigned        ACC_W         = 26;
  localparam int unsigned        ADDR_W        = 8;
  localparam logic [4:0]         FINAL_BIT     = 5'h18;
  localparam logic [4:0]         SU_PICK_BIT   = 5'h16;
  localparam logic [4:0]         DC_PICK_BIT   = 5'h17;
  localparam logic [ADDR_W-1:0]  OFS_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0]  OFS_STATUS    = 8'h04;
  localparam logic [ADDR_W-1:0]  OFS_ACC       = 8'h08;
  localparam logic [ADDR_W-1:0]  OFS_EXT       = 8'h0C;
  localparam logic [ADDR_W-1:0]  OFS_OPERAND   = 8'h10;
  localparam logic [ADDR_W-1:0]  OFS_PC        = 8'h14;
  localparam int unsigned        CTRL_MUL_BIT  = 0;
  localparam int unsigned        CTRL_DIV_BIT  = 1;
  localparam int unsigned        CTRL_OVCLR_BIT = 2;
  localparam int unsigned        ST_BUSY_BIT   = 0;
  localparam int unsigned        ST_OVF_BIT    = 1;
  localparam int unsigned        ST_PH6_BIT    = 2;
  localparam int unsigned        ST_DIV_BIT    = 3;
  localparam int unsigned        ST_BT_LSB     = 8;
  localparam logic [25:0]        ACC_RST       = 26'h000_0000;
  localparam logic [23:0]        WORD_RST      = 24'h00_0000;
  localparam logic [31:0]        ZERO_DATA     = 32'h0000_0000;
  typedef enum logic [1:0] {SMDS_IDLE, SMDS_PH0, SMDS_PH6} smds_state_t;
endpackage
`default_nettype wire

// ===== test/serial_multiply_divide_step_tb.sv
// Purpose: Self-checking bench for the multiply/divide step core
// Assumes: APB master model drives the bus, LFSR seed fixed
// Notes:   Expected values come from bench reference functions
`default_nettype none
module serial_multiply_divide_step_tb
  import smds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk, rst_b, psel, penable, pwrite, pready, pslverr, busy, ovf, pc_incr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, seed, rd;
  logic [23:0]       a, b, m;
  logic [13:0]       pc;
  logic [48:0]       ex;
  logic              err;
  int                fail_count, checks_done;
  smds_core #(.PC_W(14)) u_dut (.CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .BUSY_O(busy),
    .OVERFLOW_O(ovf), .PC_INCR_O(pc_incr));
  smds_apb_master u_host (.clk_i(clk), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [48:0] mul_ref(input logic [23:0] ai, bi, mi, input logic ov);
    logic signed [25:0] a1, a2, ms;
    int k;
    a1 = ov ? {2'b00, ai} : {{2{ai[23]}}, ai};
    ms = {{2{mi[23]}}, mi};
    case (bi[2:0])
      3'h1, 3'h2: k = 1;
      3'h3: k = 2;
      3'h4: k = -2;
      3'h5, 3'h6: k = -1;
      default: k = 0;
    endcase
    a2 = (a1 >>> 1) + 26'(k * ms);
    return {(k == -2) && (a2[25] != a2[24]), a2[24:1], a2[0], a1[0], bi[23:2]};
  endfunction
  function automatic logic [47:0] div_ref(input logic [23:0] ai, bi, mi);
    logic [23:0] sh;
    sh = {ai[22:0], bi[23]};
    return {(ai[23] == mi[23]) ? sh - mi : sh + mi, bi[22:0], ~ai[23]};
  endfunction
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] ad, input logic [31:0] wd,
                     output logic [31:0] rdo, output logic erro);
    logic ok;
    u_host.xfer(wr, ad, wd, rdo, erro, ok);
    if (!ok) begin
      fail_count++;
      $display("Error at %0t: bus stalled, ready %h expected %h", $time, 1'b0, 1'b1);
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] ad, input logic [31:0] wd);
    bus(1'b1, ad, wd, rd, err);
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] ad, input logic [31:0] exp, mask);
    bus(1'b0, ad, ZERO_DATA, rd, err);
    check(rd & mask, exp & mask);
  endtask
  task automatic load();
    wr(OFS_ACC, {8'h00, a});
    wr(OFS_EXT, {8'h00, b});
    wr(OFS_OPERAND, {8'h00, m});
    wr(OFS_PC, {18'h0_0000, pc});
  endtask
  // Poke writes land mid-step; a busy core must ignore them
  task automatic step(input logic [31:0] cmd, input logic poke);
    int n;
    wr(OFS_CTRL, cmd);
    if (poke) begin
      wr(OFS_ACC, 32'h00ff_ffff);
      wr(OFS_CTRL, cmd);
    end
    n = 0;
    do begin
      bus(1'b0, OFS_STATUS, ZERO_DATA, rd, err);
      n++;
    end while (rd[ST_BUSY_BIT] !== 1'b0 && n < 40);
    check({31'h0, rd[ST_BUSY_BIT]}, ZERO_DATA);
    if (rd[ST_BUSY_BIT] !== 1'b0) begin
      tally_and_finish();
    end
  endtask
  task automatic res(input logic [48:0] e);
    rd_chk(OFS_ACC, {8'h00, e[47:24]}, 32'hffff_ffff);
    rd_chk(OFS_EXT, {8'h00, e[23:0]}, 32'hffff_ffff);
    rd_chk(OFS_PC, {18'h0_0000, pc + 14'h0001}, 32'hffff_ffff);
    rd_chk(OFS_STATUS, {30'h0, e[48], 1'b0}, 32'h0000_0003);
  endtask
  initial begin
    fail_count = 0;
    checks_done = 0;
    seed = 32'h0000_771b;
    rst_b = 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd_chk(8'(4 * i), ZERO_DATA, 32'hffff_ffff);
    end
    wr(8'h18, 32'h0000_0001);
    bus(1'b0, 8'h18, ZERO_DATA, rd, err);
    check({err, rd[30:0]}, 32'h8000_0000);
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      a = seed[23:0];
      seed = lfsr(seed);
      m = seed[23:0];
      seed = lfsr(seed);
      b = {seed[23:3], 3'(i)};
      pc = seed[31:18];
      load();
      ex = mul_ref(a, b, m, 1'b0);
      step(32'h0000_0001, i == 5);
      res(ex);
      wr(OFS_CTRL, 32'h0000_0004);
    end
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      a = seed[23:0];
      seed = lfsr(seed);
      m = seed[23:0];
      b = {seed[31:24], seed[15:0]};
      pc = seed[13:0];
      load();
      ex = {1'b0, div_ref(a, b, m)};
      step(32'h0000_0002, i == 2);
      res(ex);
    end
    // Most negative operand: minus two leaves the 25-bit range
    a = 24'h00_0000;
    m = 24'h80_0000;
    b = 24'h00_0004;
    pc = 14'h3fff;
    load();
    ex = mul_ref(a, b, m, 1'b0);
    step(32'h0000_0001, 1'b0);
    res(ex);
    check({31'h0, ovf}, 32'h0000_0001);
    a = 24'h80_0000;
    b = 24'h00_0000;
    pc = 14'h0000;
    load();
    ex = mul_ref(a, b, m, 1'b1);
    step(32'h0000_0001, 1'b0);
    res(ex);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ===== test/smds_apb_master.sv
// Purpose: APB master standing in for software on the far side
// Assumes: One transfer at a time, idle edge between transfers
// Notes:   Released address and data lines show inverted values
`default_nettype none
module smds_apb_master
  import smds_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic [31:0]       prdata_i,
  input  wire logic              pready_i,
  input  wire logic              pslverr_i,
  output var  logic              psel_o,
  output var  logic              penable_o,
  output var  logic              pwrite_o,
  output var  logic [ADDR_W-1:0] paddr_o,
  output var  logic [31:0]       pwdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0000_0000;
  end
  // Idle edge first, so a setup never lands on a release edge
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] ad, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err, output logic ok);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= wr;
    paddr_o <= ad;
    pwdata_o <= wd;
    @(posedge clk_i);
    penable_o <= 1'b1;
    // Ready is sampled at the rising edge; release follows at that same edge
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_i !== 1'b1 && n < 16);
    rd = prdata_i;
    err = pslverr_i;
    ok = (pready_i === 1'b1);
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    paddr_o <= ~ad;
    pwdata_o <= ~wd;
  endtask
endmodule
`default_nettype wire

// ===== test/smds_core_props.sv
// Purpose: Port properties of the multiply/divide step core
// Assumes: One clock, async active-low reset
// Notes:   Bound to every smds_core instance
`default_nettype none
module smds_core_props
  import smds_pkg::*;
(
  input wire logic              CLK_I,
  input wire logic              RST_B_I,
  input wire logic              PSEL_I,
  input wire logic              PENABLE_I,
  input wire logic              PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [31:0]       PWDATA_I,
  input wire logic [31:0]       PRDATA_O,
  input wire logic              PREADY_O,
  input wire logic              PSLVERR_O,
  input wire logic              BUSY_O,
  input wire logic              OVERFLOW_O,
  input wire logic              PC_INCR_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_B_I);
  wire logic start_wr;
  assign start_wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && !BUSY_O
                    && (PADDR_I == OFS_CTRL) && (PWDATA_I[1:0] != 2'h0);
  // Two word times of 25 bit times, then the increment pulse while busy still stands
  sequence s_run;
    (BUSY_O && !PC_INCR_O) throughout (##49 1'b1);
  endsequence
  sequence s_done;
    PC_INCR_O && BUSY_O ##1 !PC_INCR_O && !BUSY_O;
  endsequence
  property p_start;
    start_wr |=> $rose(BUSY_O);
  endproperty
  a_start: assert property (p_start) else $error("Step did not start after control write");
  property p_step;
    $rose(BUSY_O) |-> s_run ##1 s_done;
  endproperty
  a_step: assert property (p_step) else $error("Step length wrong");
  property p_pc_pulse;
    PC_INCR_O |=> !PC_INCR_O;
  endproperty
  a_pc_pulse: assert property (p_pc_pulse) else $error("Increment pulse too long");
  property p_pc_src;
    PC_INCR_O |-> $past(BUSY_O);
  endproperty
  a_pc_src: assert property (p_pc_src) else $error("Increment without a step");
  property p_ovf_src;
    $rose(OVERFLOW_O) |-> $past(BUSY_O);
  endproperty
  a_ovf_src: assert property (p_ovf_src) else $error("Overflow set while idle");
  property p_rdy_wait;
    PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("Ready missing after wait state");
  property p_rdy_pulse;
    PREADY_O |=> !PREADY_O;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("Ready held too long");
  property p_err;
    PSLVERR_O |-> PREADY_O && (PRDATA_O == ZERO_DATA);
  endproperty
  a_err: assert property (p_err) else $error("Error response malformed");
  property p_upper;
    PREADY_O && !PWRITE_I |-> PRDATA_O[31:24] == 8'h00;
  endproperty
  a_upper: assert property (p_upper) else $error("Upper read bits not zero");
endmodule
bind smds_core smds_core_props u_props (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .BUSY_O(BUSY_O),
  .OVERFLOW_O(OVERFLOW_O), .PC_INCR_O(PC_INCR_O));
`default_nettype wire
